// *** rtl/fpv_pkg.sv ***
// package for the front panel status voting unit: types, encodings and timing
`default_nettype none
package fpv_pkg;
    // ========================================================
    // timing
    localparam int unsigned CLK_PERIOD_NS  = 100;           // 10 MHz system clock
    localparam int unsigned BLINK_HALF_MS  = 250;           // default flash half period
    localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned BLINK_W        = 24;            // divider counter width

    // ========================================================
    // voted status word from each slice
    typedef struct packed {
        logic active;          // module in active mode
        logic standby;         // module in standby mode
        logic educated;        // education complete
        logic educating;       // education in progress
        logic app_running;     // application program running
        logic full_integrity;  // normal operation with full integrity
        logic io_locked;       // any input or output locked
        logic cfg_mismatch;    // changeover attempted, standby config differs
        logic sys_healthy;     // no system faults
        logic sys_fault;       // boot-up, fault, self-test, bus or module error
        logic user1;           // software user lamp 1
        logic user2;           // software user lamp 2
        logic standby_present; // a standby module is fitted
        logic slice_flash_red; // a slice health lamp flashes red
    } fpv_status_type;

    localparam int unsigned STATUS_W = $bits(fpv_status_type);
    localparam fpv_status_type STATUS_RESET = '0;

    // ========================================================
    // bicolour lamp drive
    typedef struct packed {
        logic green;
        logic red;
    } fpv_lamp_type;

    // ========================================================
    // eleven front panel indicators
    typedef struct packed {
        fpv_lamp_type [2:0] slice_health;
        fpv_lamp_type       active;
        fpv_lamp_type       standby;
        fpv_lamp_type       educated;
        fpv_lamp_type       run;
        fpv_lamp_type       inhibit;
        fpv_lamp_type       sys_health;
        fpv_lamp_type       user1;
        fpv_lamp_type       user2;
    } fpv_leds_type;

    // ========================================================
    // changeover sequencer
    typedef enum logic [1:0] {
        FPV_CO_IDLE = 2'b00,
        FPV_CO_REQ  = 2'b01,
        FPV_CO_DONE = 2'b10
    } fpv_co_state_type;
endpackage : fpv_pkg
`default_nettype wire

// *** rtl/fpv_panel_vote_unit.sv ***
// front panel vote unit: votes slice status, drives lamps, buttons and changeover
`default_nettype none
module fpv_panel_vote_unit (
    input  wire logic                   clk,              // 10 MHz clock
    input  wire logic                   nrst,             // async reset, active low
    input  wire fpv_pkg::fpv_status_type slice_a,         // status from slice a
    input  wire fpv_pkg::fpv_status_type slice_b,         // status from slice b
    input  wire fpv_pkg::fpv_status_type slice_c,         // status from slice c
    input  wire logic [2:0]             slice_healthy,    // per-slice health level
    input  wire logic                   reset_button,     // fault reset button
    input  wire logic                   ews_reset,        // workstation reset command
    input  wire logic                   ews_authorised,   // password-authorised maintainer
    input  wire logic                   ews_download_req, // workstation download request
    input  wire logic                   ews_online_req,   // online parameter/command change
    input  wire logic                   key_maintain,     // keyswitch: 1 maintain, 0 run
    input  wire logic [1:0]             latch_open,       // top and bottom latch switches
    input  wire logic                   ejector_released, // ejector levers released
    input  wire logic                   changeover_ack,   // standby module took over
    output fpv_pkg::fpv_leds_type       leds,             // eleven lamps
    output logic                        fault_clear,      // clear faults and counters
    output logic                        fault_clear_req,  // ask other modules to clear
    output logic                        mem_write_lock,   // program memory locked
    output logic                        download_grant,   // download accepted
    output logic                        online_grant,     // online change accepted
    output logic [2:0]                  latch_irq,        // interrupt to each processor
    output logic                        changeover_req,   // hand over to standby
    output logic                        event_log         // changeover log strobe
);
    import fpv_pkg::*;

    // ========================================================
    // voting
    fpv_status_type voted;          // majority of the three slices
    fpv_status_type status;         // registered voted status
    logic           blink;          // shared flash phase
    logic [BLINK_W-1:0] blink_cnt;  // shared flash divider
    logic [1:0]     latch_prev;     // latch levels last cycle
    logic           button_prev;    // button level last cycle
    logic           ejector_prev;   // ejector level last cycle
    fpv_co_state_type co_state;     // changeover sequencer state
    fpv_co_state_type next_co_state;
    logic           co_trigger;     // any handover cause

    // bitwise majority keeps a single disagreeing slice from reaching a lamp
    assign voted = (slice_a & slice_b) | (slice_a & slice_c) | (slice_b & slice_c);

    // register the vote to break the path from slice pins to lamps
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            status <= STATUS_RESET;
        end else begin
            status <= voted;
        end
    end

    // ========================================================
    // blink divider
    // one free-running divider so every flashing lamp stays in phase
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            blink_cnt <= '0;
            blink     <= 1'b0;
        end else if (blink_cnt == BLINK_W'(BLINK_HALF_CYC - 1)) begin
            blink_cnt <= '0;
            blink     <= ~blink;
        end else begin
            blink_cnt <= blink_cnt + 1'b1;
        end
    end

    // ========================================================
    // indicators
    // all lamps registered; eleven in total
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            leds <= '0;
        end else begin
            // health lamps follow each slice's own level, not the vote
            for (int i = 0; i < 3; i++) begin
                leds.slice_health[i].green <= slice_healthy[i];
                leds.slice_health[i].red   <= ~slice_healthy[i];
            end
            leds.active  <= '{green: status.active,  red: 1'b0};
            leds.standby <= '{green: status.standby, red: 1'b0};
            // educated: stopped application overrides both lit states, except on a standby module
            if (!status.app_running && !status.standby) begin
                leds.educated.green <= 1'b0;
            end else if (status.educated) begin
                leds.educated.green <= 1'b1;
            end else begin
                leds.educated.green <= status.educating & blink;
            end
            leds.educated.red <= 1'b0;
            // run: standby steady wins, then normal flash, else off
            if (status.standby) begin
                leds.run.green <= 1'b1;
            end else begin
                leds.run.green <= status.app_running & status.full_integrity & blink;
            end
            leds.run.red <= 1'b0;
            leds.inhibit <= '{green: (status.io_locked | status.cfg_mismatch) & blink,
                              red: 1'b0};
            // system health: fault flash beats healthy; neither means illegal, dark
            if (status.sys_fault) begin
                leds.sys_health <= '{green: 1'b0, red: blink};
            end else begin
                leds.sys_health <= '{green: status.sys_healthy, red: 1'b0};
            end
            leds.user1 <= '{green: 1'b0, red: status.user1};
            leds.user2 <= '{green: 1'b0, red: status.user2};
        end
    end

    // ========================================================
    // fault reset
    // rising edge of button, or authorised maintainer command in maintain mode
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            button_prev     <= 1'b0;
            fault_clear     <= 1'b0;
            fault_clear_req <= 1'b0;
        end else begin
            button_prev <= reset_button;
            // one-cycle pulse per button press, workstation path lasts while ews_reset is held; testing logic elsewhere keeps running
            fault_clear     <= (reset_button & ~button_prev)
                             | (ews_reset & ews_authorised & key_maintain);
            fault_clear_req <= (reset_button & ~button_prev)
                             | (ews_reset & ews_authorised & key_maintain);
        end
    end

    // ========================================================
    // keyswitch gating
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mem_write_lock <= 1'b1;
            download_grant <= 1'b0;
            online_grant   <= 1'b0;
        end else begin
            mem_write_lock <= ~key_maintain;
            download_grant <= key_maintain & ews_authorised & ews_download_req;
            online_grant   <= key_maintain & ews_online_req;
        end
    end

    // ========================================================
    // latch interlock
    // any edge of either switch raises a pulse to all three processors
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            latch_prev <= 2'b00;
            latch_irq  <= 3'b000;
        end else begin
            latch_prev <= latch_open;
            latch_irq  <= {3{|(latch_open ^ latch_prev)}};
        end
    end

    // ========================================================
    // changeover
    // only an active module starts a handover; a standby one never does
    assign co_trigger = status.active & status.standby_present &
                        (status.slice_flash_red | (ejector_released & ~ejector_prev));

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ejector_prev <= 1'b0;
        end else begin
            ejector_prev <= ejector_released;
        end
    end

    // next state of the sequencer
    always_comb begin
        next_co_state = co_state;
        case (co_state)
            FPV_CO_IDLE: begin
                if (co_trigger) begin
                    next_co_state = FPV_CO_REQ;
                end
            end
            FPV_CO_REQ: begin
                // hold request until the standby confirms, no bump meanwhile
                if (changeover_ack) begin
                    next_co_state = FPV_CO_DONE;
                end
            end
            FPV_CO_DONE: begin
                next_co_state = FPV_CO_IDLE;
            end
            default: begin
                next_co_state = FPV_CO_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            co_state <= FPV_CO_IDLE;
        end else begin
            co_state <= next_co_state;
        end
    end

    // request and log are registered from the next-state decode, in step with the state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            changeover_req <= 1'b0;
            event_log      <= 1'b0;
        end else begin
            changeover_req <= (next_co_state == FPV_CO_REQ);
            event_log      <= (next_co_state == FPV_CO_DONE);
        end
    end

    // ========================================================
    // checks
    // a fault reset from the button is its rising edge only
    sequence btn_edge_s;
        reset_button && !button_prev;
    endsequence

    // handover steps: a trigger while idle, then the standby answer to the request
    sequence co_start_s;
        co_state == FPV_CO_IDLE && co_trigger;
    endsequence

    sequence co_answer_s;
        co_state == FPV_CO_REQ && changeover_ack;
    endsequence

    // vote and lamps
    vote_out_a: assert property (@(posedge clk) disable iff (!nrst)
        1'b1 |=> status == $past(voted)) else $error("vote not registered");
    user_lamp_a: assert property (@(posedge clk) disable iff (!nrst)
        1'b1 |=> leds.user1.red == $past(status.user1) && !leds.user1.green)
        else $error("user lamp wrong");
    active_lamp_a: assert property (@(posedge clk) disable iff (!nrst)
        1'b1 |=> leds.active.green == $past(status.active)) else $error("active lamp");
    standby_lamp_a: assert property (@(posedge clk) disable iff (!nrst)
        1'b1 |=> leds.standby.green == $past(status.standby)) else $error("standby lamp");
    // health lamps bypass the vote, so one sick slice shows on its own lamp
    health_lamp_a: assert property (@(posedge clk) disable iff (!nrst)
        1'b1 |=> leds.slice_health[1].red == !$past(slice_healthy[1]))
        else $error("health lamp wrong");
    // a fault must never leave the health lamp green, whatever the flash phase
    sys_fault_a: assert property (@(posedge clk) disable iff (!nrst)
        status.sys_fault |=> !leds.sys_health.green)
        else $error("fault shown as healthy");
    // the divider may flip the flash phase only at its wrap
    blink_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        blink_cnt != BLINK_W'(BLINK_HALF_CYC - 1) |=> blink == $past(blink))
        else $error("flash phase slipped");

    // fault reset: button edge always, workstation only authorised and in maintain
    fault_reset_a: assert property (@(posedge clk) disable iff (!nrst)
        btn_edge_s |=> fault_clear && fault_clear_req) else $error("reset lost");
    ews_gate_a: assert property (@(posedge clk) disable iff (!nrst)
        !ews_authorised && !(reset_button && !button_prev) |=> !fault_clear)
        else $error("unauthorised reset");
    ews_run_a: assert property (@(posedge clk) disable iff (!nrst)
        !key_maintain && !(reset_button && !button_prev) |=> !fault_clear_req)
        else $error("reset taken in run");
    mem_lock_a: assert property (@(posedge clk) disable iff (!nrst)
        !key_maintain |=> mem_write_lock && !download_grant && !online_grant)
        else $error("run mode not locked");

    // latch interrupt is one pulse to all processors, one cycle after the change
    latch_irq_a: assert property (@(posedge clk) disable iff (!nrst)
        $changed(latch_open) |=> latch_irq == 3'b111) else $error("latch irq");
    latch_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
        !$changed(latch_open) |=> latch_irq == 3'b000) else $error("spurious latch irq");

    // changeover: standby never starts one, an active trigger always does
    no_self_a: assert property (@(posedge clk) disable iff (!nrst)
        co_state == FPV_CO_IDLE && !status.active |=> !changeover_req)
        else $error("standby self promote");
    handover_a: assert property (@(posedge clk) disable iff (!nrst)
        co_start_s |=> changeover_req) else $error("no handover");
    req_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        co_state == FPV_CO_REQ && !changeover_ack |=> changeover_req)
        else $error("request dropped early");
    log_a: assert property (@(posedge clk) disable iff (!nrst)
        co_answer_s |=> event_log && !changeover_req) else $error("not logged");
endmodule : fpv_panel_vote_unit
`default_nettype wire

// *** testbench/fpv_slice_model.sv ***
// partner model: three processor slices feeding the panel and the standby module
`default_nettype none
module fpv_slice_model (
    input  wire logic                    clk,            // system clock
    input  wire logic                    nrst,           // async reset, active low
    input  wire fpv_pkg::fpv_status_type status,         // word the good slices agree on
    input  wire logic [1:0]              bad_slice,      // 0 none, 1..3 slice sending garbage
    input  wire logic                    changeover_req, // active module hands over
    output var  fpv_pkg::fpv_status_type slice_a,        // slice a status word
    output var  fpv_pkg::fpv_status_type slice_b,        // slice b status word
    output var  fpv_pkg::fpv_status_type slice_c,        // slice c status word
    output var  logic                    changeover_ack  // standby has taken over
);
    timeunit 1ns;
    timeprecision 1ns;
    import fpv_pkg::*;
    int unsigned cnt; // cycles since request seen
    int unsigned dly; // reply delay of this handover
    // ========================================================
    // slices: a faulty one sends the inverse so the vote must mask it
    assign slice_a = (bad_slice == 2'h1) ? ~status : status;
    assign slice_b = (bad_slice == 2'h2) ? ~status : status;
    assign slice_c = (bad_slice == 2'h3) ? ~status : status;
    // ========================================================
    // standby module: takes over only when asked, after a varying delay
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt            <= 0;
            dly            <= 1;
            changeover_ack <= 1'b0;
        end else if (!changeover_req) begin // never promotes itself
            cnt            <= 0;
            dly            <= $urandom_range(1, 6);
            changeover_ack <= 1'b0;
        end else if (cnt >= dly) begin
            changeover_ack <= 1'b1; // held until request drops
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : fpv_slice_model
`default_nettype wire

// *** testbench/tb_front_panel_status_voting.sv ***
// self-checking bench for the front panel vote unit
`default_nettype none
module tb_front_panel_status_voting;
    timeunit 1ns;
    timeprecision 1ns;
    import fpv_pkg::*;
    localparam logic [7:0] LSEQ = 8'h78; // latch pattern 01,11,10,00
    logic           clk, nrst, reset_button, ews_reset, ews_authorised;
    logic           ews_download_req, ews_online_req, key_maintain, ejector_released;
    logic           changeover_ack, fault_clear, fault_clear_req, mem_write_lock;
    logic           download_grant, online_grant, changeover_req, event_log;
    logic [1:0]     latch_open, bad_slice;
    logic [2:0]     slice_healthy, latch_irq;
    fpv_status_type st, slice_a, slice_b, slice_c; // st: word all good slices send
    fpv_leds_type   leds;
    int             fails, num_checks, n_fc, n_fr, n_irq, n_log;
    fpv_panel_vote_unit i_fpv_panel_vote_unit (.clk(clk), .nrst(nrst), .slice_a(slice_a),
        .slice_b(slice_b), .slice_c(slice_c), .slice_healthy(slice_healthy),
        .reset_button(reset_button), .ews_reset(ews_reset), .ews_authorised(ews_authorised),
        .ews_download_req(ews_download_req), .ews_online_req(ews_online_req),
        .key_maintain(key_maintain), .latch_open(latch_open),
        .ejector_released(ejector_released), .changeover_ack(changeover_ack), .leds(leds),
        .fault_clear(fault_clear), .fault_clear_req(fault_clear_req),
        .mem_write_lock(mem_write_lock), .download_grant(download_grant),
        .online_grant(online_grant), .latch_irq(latch_irq), .changeover_req(changeover_req),
        .event_log(event_log));
    fpv_slice_model i_fpv_slice_model (.clk(clk), .nrst(nrst), .status(st),
        .bad_slice(bad_slice), .changeover_req(changeover_req), .slice_a(slice_a),
        .slice_b(slice_b), .slice_c(slice_c), .changeover_ack(changeover_ack));
    // ========================================================
    // clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // pulse counters, sampled once outputs have settled
    always @(posedge clk) begin
        #5;
        n_fc  += (fault_clear === 1'b1);
        n_fr  += (fault_clear_req === 1'b1);
        n_irq += (latch_irq === 3'h7); // a partial mask never counts
        n_log += (event_log === 1'b1);
    end
    // ========================================================
    // reference lamps; run is far shorter than a flash phase, so blink stays low
    function automatic fpv_leds_type exp_leds(fpv_status_type v, logic [2:0] h);
        fpv_leds_type e;
        e = '0;
        for (int i = 0; i < 3; i++) e.slice_health[i] = {h[i], ~h[i]};
        e.active.green     = v.active;
        e.standby.green    = v.standby;
        e.educated.green   = (v.app_running | v.standby) & v.educated;
        e.run.green        = v.standby;
        e.sys_health.green = ~v.sys_fault & v.sys_healthy;
        e.user1.red        = v.user1;
        e.user2.red        = v.user2;
        return e;
    endfunction : exp_leds
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask : step
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : final_report
    // bounded wait on the handover request level
    task automatic wait_req(input logic lvl);
        int k;
        for (k = 0; k < 20 && changeover_req !== lvl; k++) step(1);
        if (changeover_req !== lvl) begin
            fails++;
            $display("[ERR] changeover_req expected %b seen %b", lvl, changeover_req);
            final_report();
        end
    endtask : wait_req
    // ========================================================
    // main sequence
    initial begin
        {nrst, reset_button, ews_reset, ews_authorised, ews_download_req} = '0;
        {ews_online_req, key_maintain, ejector_released, latch_open, bad_slice} = '0;
        {slice_healthy, st} = '0;
        {fails, num_checks} = '0;
        void'($urandom(17));
        step(4);
        check("leds rst", 32'(leds), 0);
        check("lock rst", 32'(mem_write_lock), 1);
        check("pulses rst", 32'({fault_clear, fault_clear_req, download_grant, online_grant,
            latch_irq, changeover_req, event_log}), 0);
        step(4);
        nrst = 1'b1;
        step(2);
        // fault reset: button, authorised, unauthorised, in run, button in run
        for (int k = 0; k < 5; k++) begin
            key_maintain   = (k < 3);
            ews_authorised = (k != 2);
            step(2);
            {n_fc, n_fr} = '0;
            reset_button = (k == 0 || k == 4);
            ews_reset    = (k > 0 && k < 4);
            step(1);
            {reset_button, ews_reset} = '0;
            step(4);
            check("fault_clear", 32'(n_fc), 32'(k == 0 || k == 1 || k == 4));
            check("fault_clear_req", 32'(n_fr), 32'(k == 0 || k == 1 || k == 4));
        end
        // keyswitch, authorisation and requests, every combination
        for (int i = 0; i < 16; i++) begin
            {key_maintain, ews_authorised, ews_download_req, ews_online_req} = 4'(i);
            step(2);
            check("mem_write_lock", 32'(mem_write_lock), 32'(!i[3]));
            check("download_grant", 32'(download_grant), 32'(i[3] & i[2] & i[1]));
            check("online_grant", 32'(online_grant), 32'(i[3] & i[0]));
        end
        // each latch switch change interrupts all three processors once
        for (int i = 0; i < 4; i++) begin
            n_irq = 0;
            latch_open = LSEQ[7-2*i -: 2];
            step(3);
            check("latch_irq", 32'(n_irq), 1);
        end
        // ejector release on the active module with a standby present
        st = '0;
        st.active = 1'b1;
        st.standby_present = 1'b1;
        step(3);
        check("changeover idle", 32'(changeover_req), 0);
        n_log = 0;
        ejector_released = 1'b1;
        wait_req(1'b1);
        wait_req(1'b0);
        step(2);
        check("event_log", 32'(n_log), 1);
        ejector_released = 1'b0;
        // standby module must not promote itself on any trigger
        st = '0;
        st.standby = 1'b1;
        st.standby_present = 1'b1;
        st.slice_flash_red = 1'b1;
        step(3);
        n_log = 0;
        ejector_released = 1'b1;
        step(6);
        check("standby req", 32'(changeover_req), 0);
        check("standby log", 32'(n_log), 0);
        ejector_released = 1'b0;
        // random status with at most one slice out-voted, lamps compared each time
        for (int i = 0; i < 40; i++) begin
            st            = STATUS_W'($urandom);
            slice_healthy = 3'($urandom); // each slice drives its own health level
            bad_slice     = 2'($urandom);
            step(3);
            check("leds", 32'(leds), 32'(exp_leds(st, slice_healthy)));
        end
        bad_slice = 2'h0;
        // mid-run reset: lamps, memory lock, handover request, log and latch interrupts return to their idle levels at once
        nrst = 1'b0;
        step(1);
        check("leds mid rst", 32'(leds), 0);
        check("lock mid rst", 32'(mem_write_lock), 1);
        check("req mid rst", 32'({changeover_req, event_log, latch_irq}), 0);
        nrst = 1'b1;
        step(2);
        // flashing red slice on the active module forces a handover
        st = '0;
        st.active = 1'b1;
        st.standby_present = 1'b1;
        step(3);
        wait_req(1'b0);
        step(3);
        check("flash idle", 32'(changeover_req), 0);
        st.slice_flash_red = 1'b1;
        wait_req(1'b1);
        st.slice_flash_red = 1'b0;
        wait_req(1'b0);
        step(20);
        final_report();
    end
endmodule : tb_front_panel_status_voting
`default_nettype wire
